// file: bms_pkg.sv
/*
  Shared constants and types for the boot mode selector and reset cause logic.
  Assumes a single 100 MHz clock; all flash addresses are byte addresses in user flash space.
*/
package bms_pkg;
  // ==========================================================================
  // clock and timing
  localparam longint unsigned CLK_HZ          = 64'd100_000_000;
  localparam longint unsigned FAILSAFE_TIME_S = 64'd3600;   // about one hour
  localparam logic [39:0]     FAILSAFE_CYCLES = 40'(FAILSAFE_TIME_S * CLK_HZ);
  localparam longint unsigned LIN_FAST_BAUD   = 64'd100_000;
  localparam longint unsigned BREAK_BITS      = 64'd11;     // shortest break we accept
  // least time: round up to whole cycles
  localparam int unsigned     BREAK_CYCLES    =
    int'((BREAK_BITS * CLK_HZ + LIN_FAST_BAUD - 64'd1) / LIN_FAST_BAUD);

  // ==========================================================================
  // flash layout
  localparam logic [31:0] DEBUG_ENTRY_ADDR = 32'h0000_0000;
  localparam logic [31:0] PAGE0_START_ADDR = 32'h0000_0000;
  localparam logic [31:0] PAGE0_SIG_ADDR   = 32'h0000_07fc;
  localparam logic [31:0] PAGE0_CRC_LAST   = 32'h0000_07fb;
  localparam logic [31:0] PAGE0_KEY        = 32'h1640_0000;
  localparam logic [31:0] BL_CRC_OFS       = 32'h0000_0004;
  localparam logic [31:0] BL_CRC_LAST_OFS  = 32'h0000_0005;
  localparam logic [31:0] BL_LOW_OFS       = 32'h0000_001c;
  localparam logic [31:0] BL_ENTRY_OFS     = 32'h0000_0020;
  localparam logic [31:0] BL_MAX_BYTES     = 32'h0000_7800; // 30 kB
  localparam logic [31:0] BL_UNUSED_SHORT  = 32'h0fff_ffff;
  localparam logic [31:0] BL_UNUSED_ONES   = 32'hffff_ffff;
  localparam logic [31:0] FLASH_SMALL      = 32'h0001_8000;
  localparam logic [31:0] FLASH_LARGE      = 32'h0002_0000;

  // ==========================================================================
  // software reset request
  localparam logic [31:0] IRC_REG_ADDR = 32'he000_ed0c;
  localparam logic [31:0] SW_RESET_KEY = 32'h05fa_0004;

  // ==========================================================================
  // reset cause bit positions
  localparam int CAUSE_W   = 4;
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_PIN = 1;
  localparam int CAUSE_WD  = 2;
  localparam int CAUSE_SW  = 3;
  localparam logic [3:0] CAUSE_RESET = 4'h1; // power-on leaves only its own bit

  // ==========================================================================
  // start-up sequence states, one-hot
  typedef enum logic [11:0] {
    ST_STRAP    = 12'h001,
    ST_RD_P0    = 12'h002,
    ST_CRC_P0   = 12'h004,
    ST_RD_BCRC  = 12'h008,
    ST_RD_BLOW  = 12'h010,
    ST_RD_BENT  = 12'h020,
    ST_CRC_BL   = 12'h040,
    ST_DEBUG    = 12'h080,
    ST_USER     = 12'h100,
    ST_BOOT     = 12'h200,
    ST_DNLD     = 12'h400,
    ST_FAILSAFE = 12'h800
  } bms_state_t;
endpackage : bms_pkg

// file: bms_det_if.sv
/*
  Carrier between the sequencer and each frame start detector.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface bms_det_if;
  logic sample;   // synchronous receive level
  logic arm;      // detector enabled
  logic start;    // one-cycle frame start pulse
  modport det (input sample, input arm, output start);
  modport ctl (output sample, output arm, input start);
endinterface : bms_det_if

// file: bms_break_det.sv
/*
  Frame start detector: a low level held for a full break, then the rising edge.
  Assumes the receive level is already synchronous to ref_clk.
*/
`timescale 1ns/1ps
module bms_break_det
  import bms_pkg::*;
#(
  parameter int unsigned BREAK_CYC = BREAK_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  bms_det_if.det    det
);
  // ==========================================================================
  // parameter check
  if (BREAK_CYC < 1 || BREAK_CYC > 65535) begin : g_bad_break
    $error("break length must be 1 to 65535 cycles");
  end

  localparam logic [15:0] BREAK_LAST = 16'(BREAK_CYC - 1);

  typedef struct packed {
    logic [15:0] cnt;
    logic        brk;
    logic        start;
  } bms_det_st_t;

  bms_det_st_t s_q;
  bms_det_st_t s_d;

  // ==========================================================================
  // break counting; a glitch high restarts the count
  always_comb begin
    s_d       = s_q;
    s_d.start = 1'b0;
    if (!det.arm) begin
      s_d.cnt = 16'h0000;
      s_d.brk = 1'b0;
    end else if (!det.sample) begin
      if (s_q.cnt == BREAK_LAST) begin
        s_d.brk = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end else begin
      s_d.start = s_q.brk; // delimiter edge ends the break
      s_d.brk   = 1'b0;
      s_d.cnt   = 16'h0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign det.start = s_q.start;
endmodule : bms_break_det

// file: bms_boot_sel.sv
/*
  Boot mode selector and reset cause keeper.
  Assumes reset_n is the power-on reset, other resets arrive as one-cycle events,
  and flash words and region CRCs come from an outside engine by request/ack.
*/
// What this block does
// - strap low after reset: debug start, branch to address zero, no check.
// - strap high: page zero valid when CRC word matches; branch to start.
// - fixed key in page zero validity word also counts as valid.
// - else check bootloader: CRC, lowest address, entry words at top of flash.
// - flash size parameter is 0x18000 or 0x20000 bytes.
// - bootloader invalid: enter download mode and wait for LIN data.
// - no valid LIN frame for about an hour: fail-safe until power cycle.
// - download path supports fast LIN up to 100 kbaud.
// - download mode entered only via reset; left only by another reset or the fail-safe timeout.
// - entering download mode raises the transceiver enable pin.
// - first frame start on integrated or external receive pin picks the pins.
// - pin choice automatic only in download mode; else software owns pins.
// - key written to reset control register requests a software reset.
// - each cause bit holds until software clears it.
// - pin reset does not disturb the debug session state.
// - cause bits: 3 software, 2 watchdog, 1 pin, 0 power-on.
// - SRAM invalid after power-on, else only on double-bit ECC at start-up.
// - writing one to a clear bit clears that cause bit.
`timescale 1ns/1ps
module bms_boot_sel
  import bms_pkg::*;
#(
  parameter logic [31:0] USER_FLASH_BYTES = FLASH_SMALL,
  parameter logic [39:0] FAILSAFE_CYC     = FAILSAFE_CYCLES,
  parameter int unsigned BREAK_CYC        = BREAK_CYCLES
) (
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire logic                clk_en,
  input  wire logic                debug_strap_pin,
  input  wire logic                pin_reset_event,
  input  wire logic                watchdog_reset_event,
  input  wire logic                sw_wr_valid,
  input  wire logic [31:0]         sw_wr_addr,
  input  wire logic [31:0]         sw_wr_data,
  input  wire logic                clear_wr_valid,
  input  wire logic [CAUSE_W-1:0]  clear_wr_data,
  input  wire logic                ecc_double_err,
  output logic                     flash_rd_req,
  output logic [31:0]              flash_rd_addr,
  input  wire logic                flash_rd_ack,
  input  wire logic [31:0]         flash_rd_data,
  output logic                     crc_req,
  output logic [31:0]              crc_first_addr,
  output logic [31:0]              crc_last_addr,
  input  wire logic                crc_done,
  input  wire logic [31:0]         crc_value,
  input  wire logic                lin_pin_rx,
  output logic                     lin_pin_tx,
  input  wire logic                external_receive_pin,
  output logic                     external_transmit_pin,
  output logic                     external_transmit_oe,
  output logic                     transceiver_enable_pin,
  input  wire logic                dl_tx_data,
  output logic                     dl_rx_data,
  output logic                     dl_pin_ext,
  input  wire logic                dl_frame_valid,
  output logic [11:0]              boot_state,
  output logic                     branch_valid,
  output logic [31:0]              branch_addr,
  output logic [CAUSE_W-1:0]       reset_cause_register,
  output logic                     sys_reset_req,
  output logic                     periph_reset,
  output logic                     top_die_clear,
  output logic                     sram_invalid,
  output logic                     debug_session
);
  // ==========================================================================
  // parameter checks
  if (USER_FLASH_BYTES != FLASH_SMALL && USER_FLASH_BYTES != FLASH_LARGE) begin : g_bad_size
    $error("user flash size must be 0x18000 or 0x20000");
  end
  if (FAILSAFE_CYC == 40'h00_0000_0000) begin : g_bad_timeout
    $error("fail-safe timeout must be at least one cycle");
  end

  localparam logic [31:0] BL_CRC_ADDR   = USER_FLASH_BYTES - BL_CRC_OFS;
  localparam logic [31:0] BL_LOW_ADDR   = USER_FLASH_BYTES - BL_LOW_OFS;
  localparam logic [31:0] BL_ENTRY_ADDR = USER_FLASH_BYTES - BL_ENTRY_OFS;
  localparam logic [31:0] BL_CRC_LAST   = USER_FLASH_BYTES - BL_CRC_LAST_OFS;
  localparam logic [31:0] BL_FLOOR      = USER_FLASH_BYTES - BL_MAX_BYTES;
  localparam logic [39:0] FS_LAST       = FAILSAFE_CYC - 40'h00_0000_0001;

  typedef struct packed {
    bms_state_t         st;
    logic [CAUSE_W-1:0] cause;
    logic               rd_req;
    logic [31:0]        rd_addr;
    logic               crc_req;
    logic [31:0]        crc_lo;
    logic [31:0]        crc_hi;
    logic [31:0]        sig;
    logic [31:0]        bl_low;
    logic               br_valid;
    logic [31:0]        br_addr;
    logic               xcvr_en;
    logic               sel_done;
    logic               sel_ext;
    logic               ext_tx;
    logic               ext_oe;
    logic               lin_tx;
    logic               rx;
    logic [39:0]        idle_cnt;
    logic               sys_rst;
    logic               periph_rst;
    logic               top_die;
    logic               sram_bad;
    logic               dbg;
  } bms_main_t;

  bms_main_t s_q;
  bms_main_t s_d;

  // ==========================================================================
  // frame start detectors on both receive paths
  bms_det_if lin_det ();
  bms_det_if ext_det ();

  assign lin_det.sample = lin_pin_rx;
  assign ext_det.sample = external_receive_pin;
  assign lin_det.arm    = (s_q.st == ST_DNLD) && !s_q.sel_done;
  assign ext_det.arm    = (s_q.st == ST_DNLD) && !s_q.sel_done;

  bms_break_det #(.BREAK_CYC(BREAK_CYC)) u_lin_det (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .det     (lin_det.det)
  );

  bms_break_det #(.BREAK_CYC(BREAK_CYC)) u_ext_det (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .det     (ext_det.det)
  );

  // ==========================================================================
  // reset event decode
  logic sw_key_hit;
  logic any_soft_rst;
  logic [CAUSE_W-1:0] cause_set;

  assign sw_key_hit   = sw_wr_valid && (sw_wr_addr == IRC_REG_ADDR)
                        && (sw_wr_data == SW_RESET_KEY);
  assign cause_set    = {sw_key_hit, watchdog_reset_event, pin_reset_event, 1'b0};
  assign any_soft_rst = |cause_set;

  // bootloader words must hang together before a CRC is worth running
  logic bl_entry_ok;
  assign bl_entry_ok = (flash_rd_data != BL_UNUSED_SHORT)
                       && (flash_rd_data != BL_UNUSED_ONES)
                       && flash_rd_data[0]
                       && (s_q.bl_low >= BL_FLOOR) && (s_q.bl_low < BL_ENTRY_ADDR)
                       && (flash_rd_data > s_q.bl_low)
                       && (flash_rd_data < BL_ENTRY_ADDR);

  // ==========================================================================
  // start-up sequence, pin selection and cause keeping
  always_comb begin
    s_d            = s_q;
    s_d.sys_rst    = 1'b0;
    s_d.periph_rst = 1'b0;
    s_d.top_die    = 1'b0;
    // set wins over a clear in the same cycle
    s_d.cause      = (s_q.cause & ~clear_wr_data & {CAUSE_W{clear_wr_valid}})
                     | (s_q.cause & {CAUSE_W{!clear_wr_valid}}) | cause_set;
    s_d.sys_rst    = sw_key_hit;
    if (ecc_double_err && (s_q.st inside {ST_STRAP, ST_RD_P0, ST_CRC_P0, ST_RD_BCRC,
        ST_RD_BLOW, ST_RD_BENT, ST_CRC_BL})) begin
      s_d.sram_bad = 1'b1;
    end
    case (s_q.st)
      ST_STRAP: begin
        // single sample; the decision holds until the next reset
        if (!debug_strap_pin) begin
          s_d.st       = ST_DEBUG;
          s_d.br_valid = 1'b1;
          s_d.br_addr  = DEBUG_ENTRY_ADDR;
          s_d.dbg      = 1'b1;
        end else begin
          s_d.st      = ST_RD_P0;
          s_d.rd_req  = 1'b1;
          s_d.rd_addr = PAGE0_SIG_ADDR;
        end
      end
      ST_RD_P0: begin
        if (flash_rd_ack) begin
          s_d.rd_req = 1'b0;
          s_d.sig    = flash_rd_data;
          if (flash_rd_data == PAGE0_KEY) begin
            s_d.st       = ST_USER;
            s_d.br_valid = 1'b1;
            s_d.br_addr  = PAGE0_START_ADDR;
          end else begin
            s_d.st      = ST_CRC_P0;
            s_d.crc_req = 1'b1;
            s_d.crc_lo  = PAGE0_START_ADDR;
            s_d.crc_hi  = PAGE0_CRC_LAST;
          end
        end
      end
      ST_CRC_P0: begin
        if (crc_done) begin
          s_d.crc_req = 1'b0;
          if (crc_value == s_q.sig) begin
            s_d.st       = ST_USER;
            s_d.br_valid = 1'b1;
            s_d.br_addr  = PAGE0_START_ADDR;
          end else begin
            s_d.st      = ST_RD_BCRC;
            s_d.rd_req  = 1'b1;
            s_d.rd_addr = BL_CRC_ADDR;
          end
        end
      end
      ST_RD_BCRC: begin
        if (flash_rd_ack) begin
          s_d.sig     = flash_rd_data;
          s_d.st      = ST_RD_BLOW;
          s_d.rd_addr = BL_LOW_ADDR;
        end
      end
      ST_RD_BLOW: begin
        if (flash_rd_ack) begin
          s_d.bl_low  = flash_rd_data;
          s_d.st      = ST_RD_BENT;
          s_d.rd_addr = BL_ENTRY_ADDR;
        end
      end
      ST_RD_BENT: begin
        if (flash_rd_ack) begin
          s_d.rd_req  = 1'b0;
          s_d.br_addr = flash_rd_data;
          if (bl_entry_ok) begin
            s_d.st      = ST_CRC_BL;
            s_d.crc_req = 1'b1;
            s_d.crc_lo  = s_q.bl_low;
            s_d.crc_hi  = BL_CRC_LAST;
          end else begin
            s_d.st       = ST_DNLD;
            s_d.br_addr  = DEBUG_ENTRY_ADDR;
            s_d.xcvr_en  = 1'b1;
            s_d.idle_cnt = '0;
          end
        end
      end
      ST_CRC_BL: begin
        if (crc_done) begin
          s_d.crc_req = 1'b0;
          if (crc_value == s_q.sig) begin
            s_d.st       = ST_BOOT;
            s_d.br_valid = 1'b1;
          end else begin
            s_d.st       = ST_DNLD;
            s_d.br_addr  = DEBUG_ENTRY_ADDR;
            s_d.xcvr_en  = 1'b1;
            s_d.idle_cnt = '0;
          end
        end
      end
      ST_DNLD: begin
        // plain bit path, so fast rates pass; set ahead of the fail-safe rest levels
        s_d.rx     = s_q.sel_ext ? external_receive_pin : lin_pin_rx;
        s_d.ext_tx = s_q.sel_ext ? dl_tx_data : 1'b1;
        s_d.ext_oe = s_q.sel_ext;
        s_d.lin_tx = s_q.sel_ext ? 1'b1 : dl_tx_data;
        // no exit to a run mode from here; only a reset restarts the sequence
        if (dl_frame_valid) begin
          s_d.idle_cnt = '0;
        end else if (s_q.idle_cnt == FS_LAST) begin
          s_d.st      = ST_FAILSAFE;
          s_d.xcvr_en = 1'b0;
          s_d.ext_oe  = 1'b0;
          s_d.ext_tx  = 1'b1;
          s_d.lin_tx  = 1'b1;
        end else begin
          s_d.idle_cnt = s_q.idle_cnt + 40'h00_0000_0001;
        end
        // first start wins; a tie stays on the integrated pin
        if (!s_q.sel_done && lin_det.start) begin
          s_d.sel_done = 1'b1;
        end else if (!s_q.sel_done && ext_det.start) begin
          s_d.sel_done = 1'b1;
          s_d.sel_ext  = 1'b1;
        end
      end
      ST_DEBUG, ST_USER, ST_BOOT, ST_FAILSAFE: begin
        s_d.st = s_q.st;
      end
      default: begin
        s_d.st = ST_STRAP;
      end
    endcase
    // any reset other than power-on reruns start-up with pins at rest, except in fail-safe
    if (any_soft_rst && (s_q.st != ST_FAILSAFE)) begin
      s_d.st         = ST_STRAP;
      s_d.rd_req     = 1'b0;
      s_d.crc_req    = 1'b0;
      s_d.br_valid   = 1'b0;
      s_d.br_addr    = DEBUG_ENTRY_ADDR;
      s_d.xcvr_en    = 1'b0;
      s_d.sel_done   = 1'b0;
      s_d.sel_ext    = 1'b0;
      s_d.ext_tx     = 1'b1;
      s_d.ext_oe     = 1'b0;
      s_d.lin_tx     = 1'b1;
      s_d.rx         = 1'b1;
      s_d.idle_cnt   = '0;
      s_d.periph_rst = 1'b1;
      s_d.sram_bad   = 1'b0;
      if (!pin_reset_event || watchdog_reset_event || sw_key_hit) begin
        s_d.dbg = 1'b0;
      end
    end
  end

  // ==========================================================================
  // state register; power-on reset sets its own cause and flags
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_q            <= '0;
      s_q.st         <= ST_STRAP;
      s_q.cause      <= CAUSE_RESET;
      s_q.ext_tx     <= 1'b1;
      s_q.lin_tx     <= 1'b1;
      s_q.rx         <= 1'b1;
      s_q.periph_rst <= 1'b1;
      s_q.top_die    <= 1'b1;
      s_q.sram_bad   <= 1'b1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // outputs straight from the state register
  assign flash_rd_req           = s_q.rd_req;
  assign flash_rd_addr          = s_q.rd_addr;
  assign crc_req                = s_q.crc_req;
  assign crc_first_addr         = s_q.crc_lo;
  assign crc_last_addr          = s_q.crc_hi;
  assign lin_pin_tx             = s_q.lin_tx;
  assign external_transmit_pin  = s_q.ext_tx;
  assign external_transmit_oe   = s_q.ext_oe;
  assign transceiver_enable_pin = s_q.xcvr_en;
  assign dl_rx_data             = s_q.rx;
  assign dl_pin_ext             = s_q.sel_ext;
  assign boot_state             = s_q.st;
  assign branch_valid           = s_q.br_valid;
  assign branch_addr            = s_q.br_addr;
  assign reset_cause_register   = s_q.cause;
  assign sys_reset_req          = s_q.sys_rst;
  assign periph_reset           = s_q.periph_rst;
  assign top_die_clear          = s_q.top_die;
  assign sram_invalid           = s_q.sram_bad;
  assign debug_session          = s_q.dbg;
endmodule : bms_boot_sel

// file: bms_boot_sel_chk.sv
/* Checker for the boot selector's top-level ports.
   Assumes one clock, with reset_n active low and synchronous. */
`timescale 1ns/1ps
module bms_boot_sel_chk
  import bms_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic        pin_reset_event,
  input wire logic        watchdog_reset_event,
  input wire logic        sw_wr_valid,
  input wire logic [31:0] sw_wr_addr,
  input wire logic [31:0] sw_wr_data,
  input wire logic        clear_wr_valid,
  input wire logic [3:0]  clear_wr_data,
  input wire logic [11:0] boot_state,
  input wire logic        branch_valid,
  input wire logic [31:0] branch_addr,
  input wire logic [3:0]  reset_cause_register,
  input wire logic        sys_reset_req,
  input wire logic        periph_reset,
  input wire logic        transceiver_enable_pin,
  input wire logic        debug_session
);
  // ==========================================================================
  // helper terms
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire sw_hit = sw_wr_valid && sw_wr_addr == IRC_REG_ADDR && sw_wr_data == SW_RESET_KEY;
  wire quiet  = !pin_reset_event && !watchdog_reset_event && !sw_hit;
  // ==========================================================================
  // properties
  sw_reset_req_a: assert property (clk_en && sw_hit |=>
    sys_reset_req && reset_cause_register[3]) else $error("software reset key not honoured");
  pin_cause_a: assert property (clk_en && pin_reset_event |=> reset_cause_register[1])
    else $error("pin reset cause bit not set");
  cause_hold_a: assert property (clk_en && !clear_wr_valid |=>
    (reset_cause_register & $past(reset_cause_register)) == $past(reset_cause_register))
    else $error("cause bit dropped without a clear");
  cause_clear_a: assert property (clk_en && clear_wr_valid && quiet |=>
    (reset_cause_register & $past(clear_wr_data)) == 4'h0)
    else $error("cause bit survived its clear");
  xcvr_enable_a: assert property (boot_state == ST_DNLD |-> transceiver_enable_pin)
    else $error("transceiver enable low in download");
  debug_branch_a: assert property (boot_state == ST_DEBUG |->
    branch_valid && branch_addr == 0) else $error("debug start not branching to zero");
  strap_fixed_a: assert property (clk_en && boot_state == ST_DEBUG && quiet |=>
    boot_state == ST_DEBUG) else $error("mode left without a reset");
  pin_restart_a: assert property (clk_en && pin_reset_event && boot_state != ST_FAILSAFE |=>
    boot_state == ST_STRAP && periph_reset) else $error("pin reset did not restart");
  debug_keep_a: assert property (clk_en && debug_session && pin_reset_event && !sw_hit &&
    !watchdog_reset_event |=> debug_session) else $error("pin reset cut debug");
  cover property (boot_state == ST_BOOT);
  cover property (boot_state == ST_FAILSAFE);
  cover property (sys_reset_req);
endmodule : bms_boot_sel_chk

bind bms_boot_sel bms_boot_sel_chk u_chk (.*);

// file: bms_flash_model.sv
/* Flash image and CRC engine standing at the selector's far side.
   Assumes the bench supplies the image words; answers by request and ack. */
`timescale 1ns/1ps
module bms_flash_model
  import bms_pkg::*;
#(parameter logic [31:0] SIZE = FLASH_SMALL)
(
  input  wire logic        ref_clk,
  input  wire logic        flash_rd_req,
  input  wire logic [31:0] flash_rd_addr,
  output logic             flash_rd_ack,
  output logic [31:0]      flash_rd_data,
  input  wire logic        crc_req,
  input  wire logic [31:0] crc_first_addr,
  output logic             crc_done,
  output logic [31:0]      crc_value,
  input  wire logic [31:0] p0_word,
  input  wire logic [31:0] bent_word,
  input  wire logic [31:0] crc0_val,
  input  wire logic [31:0] crcb_val
);
  // ==========================================================================
  // image lookup
  logic [2:0]  wait_q = 3'h0;
  logic [31:0] word;
  logic [31:0] sum;
  // unmapped places read back as the inverted address
  always_comb begin
    case (flash_rd_addr)
      PAGE0_SIG_ADDR:      word = p0_word;
      SIZE - BL_CRC_OFS:   word = crc0_val;
      SIZE - BL_LOW_OFS:   word = SIZE - BL_MAX_BYTES;
      SIZE - BL_ENTRY_OFS: word = bent_word;
      default:             word = ~flash_rd_addr;
    endcase
    sum = crc_first_addr == PAGE0_START_ADDR ? crc0_val : crcb_val;
  end
  // wait depends on address, so some answers are prompt and some slow
  always @(posedge ref_clk) begin
    flash_rd_ack <= 1'b0;
    crc_done <= 1'b0;
    flash_rd_data <= ~word;
    crc_value <= ~sum;
    wait_q <= (flash_rd_req || crc_req) && !flash_rd_ack && !crc_done ? wait_q + 3'h1 : 3'h0;
    if (flash_rd_req && !flash_rd_ack && wait_q == flash_rd_addr[5:3]) begin
      flash_rd_ack <= 1'b1;
      flash_rd_data <= word;
    end
    if (crc_req && !crc_done && wait_q == 3'h4) begin
      crc_done <= 1'b1;
      crc_value <= sum;
    end
  end
endmodule : bms_flash_model

// file: bms_boot_sel_tb_top.sv
/* Bench for the boot selector: drives resets and image words, checks modes.
   Assumes the flash model as far side and shortened break and fail-safe counts. */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module bms_boot_sel_tb_top
  import bms_pkg::*;
;
  logic ref_clk = 0, reset_n = 0, clk_en = 1, debug_strap_pin = 0, pin_reset_event = 0;
  logic watchdog_reset_event = 0, sw_wr_valid = 0, clear_wr_valid = 0, ecc_double_err = 0;
  logic lin_pin_rx = 1, external_receive_pin = 1, dl_tx_data = 0, dl_frame_valid = 0;
  logic [31:0] sw_wr_addr = IRC_REG_ADDR, sw_wr_data = SW_RESET_KEY;
  logic [3:0] clear_wr_data = 4'h0, reset_cause_register;
  logic flash_rd_req, flash_rd_ack, crc_req, crc_done, lin_pin_tx, external_transmit_pin;
  logic external_transmit_oe, transceiver_enable_pin, dl_rx_data, dl_pin_ext, branch_valid;
  logic sys_reset_req, periph_reset, top_die_clear, sram_invalid, debug_session, term_q = 0;
  logic [31:0] flash_rd_addr, flash_rd_data, crc_first_addr, crc_last_addr, crc_value;
  logic [31:0] branch_addr, p0_word, bent_word, crc0_val, crcb_val;
  logic [11:0] boot_state;
  logic [43:0] notes[$], note;
  logic [31:0] bad_entry[4] = '{BL_UNUSED_ONES, 32'h1_0800, 32'h1_0801, BL_UNUSED_SHORT};
  int seed = 73049, mismatches = 0, total_checks = 0, cycles = 0;
  bms_boot_sel #(.FAILSAFE_CYC(40'd200), .BREAK_CYC(8)) DUT (.*);
  bms_flash_model fm (.*);
  // ==========================================================================
  // clock, timeout and verdict
  always #5 ref_clk = ~ref_clk;
  // a hang counts as a mismatch so the verdict still prints
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic finish_test;
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  // each start-up that lands in a final mode takes the oldest note
  always @(posedge ref_clk) begin
    if (reset_n && |(boot_state & 12'h780) && !term_q) begin
      if (notes.size() == 0) `CHK(1'b0, 1'b1)
      else begin
        note = notes.pop_front();
        `CHK({boot_state, branch_addr}, note)
      end
    end
    term_q = |(boot_state & 12'h780);
  end
  // ==========================================================================
  // one soft reset with a fresh image; pm picks crc, key or a bad word
  task automatic run(input int ev, input logic strap, input int pm, input logic bm,
                     input logic [31:0] be, input logic [11:0] st, input logic [31:0] ad);
    crc0_val = $random(seed);
    crcb_val = bm ? ~crc0_val : crc0_val;
    p0_word = pm == 0 ? crc0_val : pm == 1 ? PAGE0_KEY : 32'h0;
    bent_word = be;
    debug_strap_pin = strap;
    notes.push_back({st, ad});
    pin_reset_event = ev == 0;
    watchdog_reset_event = ev == 1;
    sw_wr_valid = ev == 2;
    @(negedge ref_clk);
    {pin_reset_event, watchdog_reset_event, sw_wr_valid} = 3'h0;
    wait (notes.size() == 0);
    @(negedge ref_clk);
  endtask : run
  // ==========================================================================
  // main sequence
  initial begin
    notes.push_back({ST_DEBUG, DEBUG_ENTRY_ADDR});
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    wait (notes.size() == 0);
    @(negedge ref_clk);
    run(0, 1, 0, 0, BL_UNUSED_ONES, ST_USER, PAGE0_START_ADDR);
    `CHK({sram_invalid, top_die_clear}, 2'h0)
    run(1, 1, 1, 0, BL_UNUSED_ONES, ST_USER, PAGE0_START_ADDR);
    sw_wr_data = ~SW_RESET_KEY;
    sw_wr_valid = 1'b1;
    @(negedge ref_clk);
    sw_wr_valid = 1'b0;
    sw_wr_data = SW_RESET_KEY;
    `CHK(sys_reset_req, 1'b0)
    run(2, 1, 2, 0, 32'h1_0801, ST_BOOT, 32'h1_0801);
    `CHK(reset_cause_register, 4'hf)
    clear_wr_data = 4'h5;
    clear_wr_valid = 1'b1;
    @(negedge ref_clk);
    clear_wr_valid = 1'b0;
    `CHK(reset_cause_register, 4'ha)
    foreach (bad_entry[i]) run(0, 1, 2, i == 2, bad_entry[i], ST_DNLD, 32'h0);
    // break on the external receive line only
    external_receive_pin = 1'b0;
    repeat (10) @(negedge ref_clk);
    external_receive_pin = 1'b1;
    repeat (4) @(negedge ref_clk);
    `CHK({dl_pin_ext, external_transmit_oe}, 2'h3)
    repeat (250) @(negedge ref_clk);
    `CHK({boot_state, external_transmit_oe}, {ST_FAILSAFE, 1'b0})
    pin_reset_event = 1'b1;
    @(negedge ref_clk);
    pin_reset_event = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK(boot_state, ST_FAILSAFE)
    notes.push_back({ST_DNLD, 32'h0});
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    wait (notes.size() == 0);
    @(negedge ref_clk);
    `CHK(reset_cause_register, 4'h1)
    finish_test();
  end
endmodule : bms_boot_sel_tb_top
